// ==== src/vcd_pkg.sv ====
// shared types and constants of the voltage channel datapath
`default_nettype none
package vcd_pkg;
  // ******************************************************************
  // clock and timing
  // ******************************************************************
  localparam int CLK_HZ = 200_000_000;
  localparam int SAMPLE_RATE_HZ = 8000;
  localparam int SAMPLE_DIV_CYC = CLK_HZ / SAMPLE_RATE_HZ;
  localparam int PIN_DELAY_NS = 70;
  localparam int PIN_DELAY_CYC = PIN_DELAY_NS * (CLK_HZ / 1_000_000) / 1000;
  localparam int PIN_LOW_NS = 10_000;
  localparam int PIN_LOW_CYC = PIN_LOW_NS * (CLK_HZ / 1_000_000) / 1000;
  localparam int HPF_SHIFT = 8;
  // ******************************************************************
  // register map and fields
  // ******************************************************************
  localparam logic [15:0] STATUS_FLAGS_ZERO_ADDR = 16'he502;
  localparam logic [15:0] INTERRUPT_ENABLE_ZERO_ADDR = 16'he50a;
  localparam logic [15:0] SETUP_ADDR = 16'he618;
  localparam logic [15:0] GAIN_BASE = 16'h4380;
  localparam logic [15:0] WAVE_BASE = 16'he440;
  localparam int READY_BIT = 17;
  localparam int FILTER_EN_BIT = 4;
  localparam int PIN_FN_LSB = 0;
  localparam int STEER_A_LSB = 8;
  localparam int STEER_B_LSB = 10;
  localparam int STEER_C_LSB = 12;
  localparam logic [15:0] SETUP_RST = 16'h0010;
  localparam logic [31:0] INTERRUPT_ENABLE_ZERO_RST = 32'h0000_0000;
  localparam logic [23:0] GAIN_RST = 24'h00_0000;
  localparam logic signed [25:0] GAIN_ONE = 26'sh080_0000;
  localparam int NCH = 8;
  // ******************************************************************
  // types
  // ******************************************************************
  typedef logic [NCH-1:0][23:0] vcd_chan_vec_t;
  typedef logic [2:0][23:0] vcd_phase_vec_t;
  typedef struct packed {
    logic [15:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } vcd_reg_req_t;
  typedef struct packed {
    logic [31:0] rdata;
    logic rvalid;
  } vcd_reg_rsp_t;
  typedef enum logic [2:0] {
    PIN_IDLE = 3'b001,
    PIN_DELAY = 3'b010,
    PIN_LOW = 3'b100
  } vcd_pin_state_t;
  typedef struct packed {
    logic [14:0] div_cnt;
    logic s1_v;
    logic s2_v;
    logic [NCH-1:0][31:0] dc;
    vcd_chan_vec_t filt;
    vcd_chan_vec_t gain;
    vcd_chan_vec_t wave;
    logic [15:0] setup;
    logic [31:0] mask;
    logic ready;
    logic irq_n;
    vcd_pin_state_t pin_st;
    logic [10:0] pin_cnt;
    logic pin_n;
    vcd_reg_rsp_t rsp;
    vcd_phase_vec_t volt;
    vcd_phase_vec_t power;
  } vcd_state_t;
endpackage
`default_nettype wire

// ==== src/vcd_top.sv ====
// voltage channel gain, high-pass filter, sampling, ready signalling and phase steering
`default_nettype none
// Behaviour
// - each voltage is scaled by one plus signed 24-bit gain over 2^23
// - gain 0x400000 raises by half, 0xc00000 lowers by half
// - gained voltage feeds samples, steering and power alike
// - gain reads as 28-bit sign extension followed by four zero bits
// - filter-enable bit 4 of setup turns dc-removing filters on, default on
// - filtered, gained samples land in eight sample registers every 8 kHz tick
// - sample register updates never stall power computation
// - status bit 17 sets when fresh samples are readable
// - mask bit 17 enables an interrupt on each ready set
// - pin function 00: event pin low 70 ns after ready, for 10 us
// - samples read as 32-bit words with sign copied into top byte
// - setup bits 9:8 steer A, B, C or A into phase A path
// - setup bits 11:10 steer B, C, A or B into phase B path
// - setup bits 13:12 steer C, A, B or C into phase C path
// - each phase power multiplies the steered voltage by its own current
// - interrupt pin low while enabled ready set; writing one clears it
module vcd_top #(
  parameter int SAMPLE_DIV = vcd_pkg::SAMPLE_DIV_CYC
) (
  // clock and reset
  input wire logic MCLK_I,
  input wire logic RESETN_I,
  // adc samples and phase currents, same clock domain
  input wire vcd_pkg::vcd_chan_vec_t ADC_SAMPLE_I,
  input wire vcd_pkg::vcd_phase_vec_t PHASE_CURRENT_I,
  input wire logic ZERO_CROSS_LEVEL_I,
  // register port of the serial interface
  input wire vcd_pkg::vcd_reg_req_t REG_REQ_I,
  output var vcd_pkg::vcd_reg_rsp_t REG_RSP_O,
  // pins
  output logic INTERRUPT_PIN_ZERO_N_O,
  output logic SHARED_EVENT_PIN_N_O,
  // power datapath
  output var vcd_pkg::vcd_phase_vec_t PHASE_VOLTAGE_O,
  output var vcd_pkg::vcd_phase_vec_t PHASE_POWER_O
);
  import vcd_pkg::*;

  // ******************************************************************
  // helpers
  // ******************************************************************
  function automatic logic [23:0] sat24(input logic signed [49:0] x);
    logic [23:0] r;
    r = x[23:0];
    if (x > 50'sd8388607)
    begin
      r = 24'h7f_ffff;
    end
    else if (x < -50'sd8388608)
    begin
      r = 24'h80_0000;
    end
    return r;
  endfunction

  function automatic logic [49:0] sext24(input logic [23:0] v);
    return {{26{v[23]}}, v};
  endfunction

  // address falls into an aligned bank of eight channel registers
  function automatic logic bank_hit(input logic [15:0] addr, input logic [15:0] base);
    return addr[15:3] == base[15:3];
  endfunction

  // phase p receives its own voltage for codes 00 and 11
  function automatic logic [1:0] steer_src(input logic [1:0] code, input int p);
    logic [1:0] r;
    r = 2'(p);
    case (code)
      2'b01: r = 2'((p + 1) % 3);
      2'b10: r = 2'((p + 2) % 3);
      default: r = 2'(p);
    endcase
    return r;
  endfunction

  // ******************************************************************
  // state
  // ******************************************************************
  vcd_state_t st_r;
  vcd_state_t st_nxt;
  logic tick;
  logic clr_ready;
  logic [1:0] pin_fn;
  logic signed [31:0] xe;
  logic signed [31:0] err;
  logic signed [25:0] fac;
  logic signed [49:0] prod;
  logic [1:0] src;

  assign tick = st_r.div_cnt == 15'(SAMPLE_DIV - 1);
  assign pin_fn = st_r.setup[PIN_FN_LSB +: 2];
  assign clr_ready = REG_REQ_I.wr && REG_REQ_I.addr == STATUS_FLAGS_ZERO_ADDR
    && REG_REQ_I.wdata[READY_BIT];

  always_comb
  begin
    xe = '0;
    err = '0;
    fac = '0;
    prod = '0;
    src = '0;
    st_nxt = st_r;
    st_nxt.div_cnt = tick ? 15'd0 : st_r.div_cnt + 15'd1;
    st_nxt.s1_v = tick;
    st_nxt.s2_v = st_r.s1_v;
    st_nxt.rsp.rvalid = 1'b0;

    // ****************************************************************
    // stage 1: dc removal, runs on the 8 kHz tick
    // ****************************************************************
    for (int i = 0; i < NCH; i++)
    begin
      xe = $signed({ADC_SAMPLE_I[i], 8'h00});
      err = xe - $signed(st_r.dc[i]);
      if (tick)
      begin
        if (st_r.setup[FILTER_EN_BIT])
        begin
          st_nxt.dc[i] = 32'($signed(st_r.dc[i]) + (err >>> HPF_SHIFT));
          st_nxt.filt[i] = sat24($signed({{18{err[31]}}, err}) >>> 8);
        end
        else
        begin
          st_nxt.filt[i] = ADC_SAMPLE_I[i];
        end
      end
    end

    // ****************************************************************
    // stage 2: gain and sample capture
    // ****************************************************************
    for (int i = 0; i < NCH; i++)
    begin
      fac = GAIN_ONE + $signed({{2{st_r.gain[i][23]}}, st_r.gain[i]});
      prod = $signed(sext24(st_r.filt[i])) * $signed({{24{fac[25]}}, fac});
      if (st_r.s1_v)
      begin
        // the sample bank is its own register set, power keeps running
        st_nxt.wave[i] = sat24(prod >>> 23);
      end
    end

    // ****************************************************************
    // stage 3: steering into the phase power paths
    // ****************************************************************
    for (int p = 0; p < 3; p++)
    begin
      case (p)
        0: src = steer_src(st_r.setup[STEER_A_LSB +: 2], p);
        1: src = steer_src(st_r.setup[STEER_B_LSB +: 2], p);
        default: src = steer_src(st_r.setup[STEER_C_LSB +: 2], p);
      endcase
      prod = $signed(sext24(st_r.wave[{src, 1'b0}]))
        * $signed(sext24(PHASE_CURRENT_I[p]));
      if (st_r.s2_v)
      begin
        st_nxt.volt[p] = st_r.wave[{src, 1'b0}];
        st_nxt.power[p] = sat24(prod >>> 23);
      end
    end

    // ****************************************************************
    // register writes
    // ****************************************************************
    if (REG_REQ_I.wr)
    begin
      if (REG_REQ_I.addr == SETUP_ADDR)
      begin
        st_nxt.setup = REG_REQ_I.wdata[15:0];
      end
      if (REG_REQ_I.addr == INTERRUPT_ENABLE_ZERO_ADDR)
      begin
        st_nxt.mask = REG_REQ_I.wdata;
      end
      if (bank_hit(REG_REQ_I.addr, GAIN_BASE))
      begin
        st_nxt.gain[REG_REQ_I.addr[2:0]] = REG_REQ_I.wdata[27:4];
      end
    end

    // a new sample wins over a clear in the same cycle
    st_nxt.ready = (st_r.ready && !clr_ready) || st_r.s1_v;
    st_nxt.irq_n = !(st_nxt.ready && st_nxt.mask[READY_BIT]);

    // ****************************************************************
    // register reads, answered one cycle later
    // ****************************************************************
    if (REG_REQ_I.rd)
    begin
      st_nxt.rsp.rvalid = 1'b1;
      st_nxt.rsp.rdata = 32'h0000_0000;
      if (REG_REQ_I.addr == STATUS_FLAGS_ZERO_ADDR)
      begin
        st_nxt.rsp.rdata[READY_BIT] = st_r.ready;
      end
      if (REG_REQ_I.addr == INTERRUPT_ENABLE_ZERO_ADDR)
      begin
        st_nxt.rsp.rdata = st_r.mask;
      end
      if (REG_REQ_I.addr == SETUP_ADDR)
      begin
        st_nxt.rsp.rdata = {16'h0000, st_r.setup};
      end
      if (bank_hit(REG_REQ_I.addr, GAIN_BASE))
      begin
        st_nxt.rsp.rdata = {{4{st_r.gain[REG_REQ_I.addr[2:0]][23]}},
          st_r.gain[REG_REQ_I.addr[2:0]], 4'h0};
      end
      if (bank_hit(REG_REQ_I.addr, WAVE_BASE))
      begin
        st_nxt.rsp.rdata = {{8{st_r.wave[REG_REQ_I.addr[2:0]][23]}},
          st_r.wave[REG_REQ_I.addr[2:0]]};
      end
    end

    // ****************************************************************
    // shared event pin
    // ****************************************************************
    case (st_r.pin_st)
      PIN_IDLE:
      begin
        st_nxt.pin_n = 1'b1;
        if (st_r.s1_v)
        begin
          st_nxt.pin_st = PIN_DELAY;
          st_nxt.pin_cnt = 11'd0;
        end
      end
      PIN_DELAY:
      begin
        st_nxt.pin_cnt = st_r.pin_cnt + 11'd1;
        if (st_r.pin_cnt == 11'(PIN_DELAY_CYC - 1))
        begin
          st_nxt.pin_st = PIN_LOW;
          st_nxt.pin_cnt = 11'd0;
          st_nxt.pin_n = 1'b0;
        end
      end
      PIN_LOW:
      begin
        st_nxt.pin_cnt = st_r.pin_cnt + 11'd1;
        if (st_r.pin_cnt == 11'(PIN_LOW_CYC - 1))
        begin
          // rising edge is the host's burst-read trigger
          st_nxt.pin_st = PIN_IDLE;
          st_nxt.pin_n = 1'b1;
        end
      end
      default:
      begin
        st_nxt.pin_st = PIN_IDLE;
        st_nxt.pin_n = 1'b1;
      end
    endcase
    // any other function code aborts a pulse and follows zero-crossing
    if (pin_fn != 2'b00)
    begin
      st_nxt.pin_st = PIN_IDLE;
      st_nxt.pin_n = ZERO_CROSS_LEVEL_I;
    end
  end

  always_ff @(posedge MCLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      st_r <= '0;
      st_r.setup <= SETUP_RST;
      st_r.mask <= INTERRUPT_ENABLE_ZERO_RST;
      st_r.gain <= {NCH{GAIN_RST}};
      st_r.irq_n <= 1'b1;
      st_r.pin_n <= 1'b1;
      st_r.pin_st <= PIN_IDLE;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign REG_RSP_O = st_r.rsp;
  assign INTERRUPT_PIN_ZERO_N_O = st_r.irq_n;
  assign SHARED_EVENT_PIN_N_O = st_r.pin_n;
  assign PHASE_VOLTAGE_O = st_r.volt;
  assign PHASE_POWER_O = st_r.power;

  // ******************************************************************
  // checks
  // ******************************************************************
  logic [11:0] low_len_r;

  always_ff @(posedge MCLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      low_len_r <= 12'd0;
    end
    else
    begin
      low_len_r <= st_r.pin_n ? 12'd0 : low_len_r + 12'd1;
    end
  end

  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (!RESETN_I);

  sequence seq_pin_wait;
    st_r.pin_n [*8] ##1 st_r.pin_n [*6];
  endsequence

  sequence seq_pin_fall;
    seq_pin_wait ##1 !st_r.pin_n;
  endsequence

  AST_GAIN_UNITY: assert property (
    st_r.s1_v && st_r.gain[0] == 24'h00_0000 |=> st_r.wave[0] == $past(st_r.filt[0]))
    else $error("unity gain altered sample");
  AST_GAIN_HALF_UP: assert property (
    st_r.s1_v && st_r.gain[0] == 24'h40_0000 && st_r.filt[0][23:22] == 2'b00
    |=> st_r.wave[0] == $past(st_r.filt[0]) + ($past(st_r.filt[0]) >> 1))
    else $error("gain 0x400000 did not add half");
  AST_GAIN_HALF_DN: assert property (
    st_r.s1_v && st_r.gain[2] == 24'hc0_0000
    |=> st_r.wave[2] == 24'($signed($past(st_r.filt[2])) >>> 1))
    else $error("gain 0xc00000 did not remove half");
  AST_FILTER_BYPASS: assert property (
    tick && !st_r.setup[FILTER_EN_BIT] |=> st_r.filt[1] == $past(ADC_SAMPLE_I[1]))
    else $error("bypassed filter changed sample");
  AST_READY_AFTER_TICK: assert property (
    tick |-> ##2 st_r.ready ##1 st_r.s2_v == 1'b0)
    else $error("ready flag missing after sample tick");
  AST_IRQ_LOW: assert property (
    st_r.ready && st_r.mask[READY_BIT] |-> !INTERRUPT_PIN_ZERO_N_O)
    else $error("interrupt pin high while enabled ready set");
  AST_IRQ_CLEAR: assert property (
    clr_ready && !st_r.s1_v |=> !st_r.ready && INTERRUPT_PIN_ZERO_N_O)
    else $error("write one did not clear ready");
  AST_PIN_FALL: assert property (
    st_r.s1_v && pin_fn == 2'b00 && st_r.pin_st == PIN_IDLE |=> seq_pin_fall)
    else $error("event pin did not fall 14 cycles after ready");
  AST_PIN_LOW_LEN: assert property (
    $rose(st_r.pin_n) && $past(pin_fn) == 2'b00 |-> low_len_r == 12'd2000)
    else $error("event pin low time wrong");
  AST_PIN_ZX: assert property (
    pin_fn != 2'b00 |=> SHARED_EVENT_PIN_N_O == $past(ZERO_CROSS_LEVEL_I))
    else $error("event pin not following zero-crossing");
  AST_STEER_A: assert property (
    st_r.s2_v && st_r.setup[STEER_A_LSB +: 2] == 2'b01
    |=> PHASE_VOLTAGE_O[0] == $past(st_r.wave[2]))
    else $error("phase a path not fed by phase b");
  AST_STEER_B: assert property (
    st_r.s2_v && st_r.setup[STEER_B_LSB +: 2] == 2'b10
    |=> PHASE_VOLTAGE_O[1] == $past(st_r.wave[0]))
    else $error("phase b path not fed by phase a");
  AST_STEER_C: assert property (
    st_r.s2_v && st_r.setup[STEER_C_LSB +: 2] == 2'b11
    |=> PHASE_VOLTAGE_O[2] == $past(st_r.wave[4]))
    else $error("phase c path not fed by phase c");
  AST_GAIN_READ: assert property (
    REG_REQ_I.rd && REG_REQ_I.addr == GAIN_BASE && !REG_REQ_I.wr
    |=> REG_RSP_O.rvalid && REG_RSP_O.rdata[3:0] == 4'h0
    && REG_RSP_O.rdata[31:27] == {5{$past(st_r.gain[0][23])}})
    else $error("gain word layout wrong");
  AST_WAVE_READ: assert property (
    REG_REQ_I.rd && REG_REQ_I.addr == WAVE_BASE && !st_r.s1_v
    |=> REG_RSP_O.rdata == {{8{$past(st_r.wave[0][23])}}, $past(st_r.wave[0])})
    else $error("sample word not sign extended");
endmodule
`default_nettype wire

// ==== verification/test_vcd_top.sv ====
// self-checking bench of the voltage channel datapath
`default_nettype none
module test_vcd_top;
  timeunit 1ns;
  timeprecision 1ps;
  import vcd_pkg::*;
  // ******************************************************************
  // harness
  // ******************************************************************
  // tick spacing above the 2014-cycle pin pulse so every pulse is seen
  localparam int DIV = 2100;
  logic clk;
  logic rst_n;
  logic zx_lvl;
  logic irq_n;
  logic ev_n;
  vcd_chan_vec_t adc;
  vcd_chan_vec_t gset;
  vcd_phase_vec_t cur;
  vcd_phase_vec_t volt;
  vcd_phase_vec_t pwr;
  vcd_reg_req_t req;
  vcd_reg_rsp_t rsp;
  int failures;
  int samples_checked;
  vcd_top #(.SAMPLE_DIV(DIV)) dut (.MCLK_I(clk), .RESETN_I(rst_n), .ADC_SAMPLE_I(adc),
    .PHASE_CURRENT_I(cur), .ZERO_CROSS_LEVEL_I(zx_lvl), .REG_REQ_I(req), .REG_RSP_O(rsp),
    .INTERRUPT_PIN_ZERO_N_O(irq_n), .SHARED_EVENT_PIN_N_O(ev_n), .PHASE_VOLTAGE_O(volt),
    .PHASE_POWER_O(pwr));
  vcd_host host (.clk_i(clk), .req_o(req), .rsp_i(rsp), .event_pin_n_i(ev_n));
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ******************************************************************
  // helpers
  // ******************************************************************
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic chk_rd(input string name, input logic [15:0] a, input logic [31:0] exp);
    logic [31:0] v;
    host.rd(a, v);
    check(name, v, exp);
  endtask
  function automatic logic [23:0] scaled(input int ch);
    logic signed [47:0] x;
    x = $signed(adc[ch]);
    return 24'(x + ((x * $signed(gset[ch])) >>> 23));
  endfunction
  // two clear-and-wait rounds so the data reflects settings written before
  task automatic fresh();
    logic [31:0] d;
    int n;
    for (int r = 0; r < 2; r++)
    begin
      host.wr(STATUS_FLAGS_ZERO_ADDR, 32'h1 << READY_BIT);
      d = '0;
      n = 0;
      while (d[READY_BIT] !== 1'b1 && n < 1500)
      begin
        host.rd(STATUS_FLAGS_ZERO_ADDR, d);
        n++;
      end
      check("ready", {31'h0, d[READY_BIT]}, 32'h1);
    end
  endtask
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    repeat (90000) @(posedge clk);
    failures++;
    tally_and_finish();
  end
  // ******************************************************************
  // tests
  // ******************************************************************
  initial
  begin
    logic [31:0] d;
    logic [23:0] e;
    logic signed [47:0] pe;
    int n;
    int m;
    int ok;
    int src;
    rst_n = 1'b0;
    zx_lvl = 1'b1;
    adc = {24'hfff000, 24'h000600, 24'h000500, 24'h000800, 24'h000300, 24'hffe000,
      24'h000200, 24'h001000};
    gset = '0;
    cur = {24'h100000, 24'h200000, 24'h400000};
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    chk_rd("setup", SETUP_ADDR, 32'h0000_0010);
    chk_rd("mask", INTERRUPT_ENABLE_ZERO_ADDR, 32'h0);
    chk_rd("unmapped", 16'h1234, 32'h0);
    chk_rd("gain", GAIN_BASE, 32'h0);
    fresh();
    fresh();
    host.rd(WAVE_BASE, d);
    check("hpf_on", {31'h0, $signed(d) < 32'sh1000}, 32'h1);
    host.rd(WAVE_BASE + 16'h2, d);
    check("hpf_neg", {31'h0, $signed(d) > -32'sh2000 && $signed(d) < 0}, 32'h1);
    // upper nibble of the write is junk and must not reach the gain
    host.wr(GAIN_BASE, 32'h0400_0000);
    host.wr(GAIN_BASE + 16'h2, 32'hac00_0000);
    gset[0] = 24'h400000;
    gset[2] = 24'hc00000;
    chk_rd("gain_a", GAIN_BASE, 32'h0400_0000);
    chk_rd("gain_b", GAIN_BASE + 16'h2, 32'hfc00_0000);
    host.wr(SETUP_ADDR, 32'h0);
    fresh();
    for (int i = 0; i < NCH; i++)
    begin
      host.rd(WAVE_BASE + 16'(i), d);
      e = scaled(i);
      check("wave", d, {{8{e[23]}}, e});
    end
    for (int k = 0; k < 4; k++)
    begin
      host.wr(SETUP_ADDR, 32'(k * 32'h1500));
      fresh();
      repeat (4) @(posedge clk);
      for (int p = 0; p < 3; p++)
      begin
        src = (k == 0 || k == 3) ? p : (p + k) % 3;
        e = scaled(2 * src);
        pe = $signed(e) * $signed(cur[p]);
        check("volt", {8'h0, volt[p]}, {8'h0, e});
        check("power", {8'h0, pwr[p]}, {8'h0, 24'(pe >>> 23)});
      end
    end
    host.wr(INTERRUPT_ENABLE_ZERO_ADDR, 32'h1 << READY_BIT);
    host.wr(STATUS_FLAGS_ZERO_ADDR, 32'h1 << READY_BIT);
    n = 0;
    // pins are looked at on the falling edge, away from the edge that launches them
    @(negedge clk);
    while (irq_n !== 1'b0 && n < 2200)
    begin
      @(negedge clk);
      n++;
    end
    check("irq", {31'h0, irq_n}, 32'h0);
    n = 0;
    while (ev_n !== 1'b0 && n < 40)
    begin
      @(negedge clk);
      n++;
    end
    check("pin_delay", n, 32'd14);
    n = 0;
    while (ev_n === 1'b0 && n < 2100)
    begin
      @(negedge clk);
      n++;
    end
    check("pin_low", n, 32'd2000);
    chk_rd("status", STATUS_FLAGS_ZERO_ADDR, 32'h1 << READY_BIT);
    host.wr(STATUS_FLAGS_ZERO_ADDR, 32'h1 << READY_BIT);
    @(posedge clk);
    check("irq_clear", {31'h0, irq_n}, 32'h1);
    host.burst(ok);
    check("burst", ok, 32'h1);
    for (int i = 0; i < NCH; i++)
    begin
      e = scaled(i);
      check("burst_wave", host.burst_q[i], {{8{e[23]}}, e});
    end
    host.wr(INTERRUPT_ENABLE_ZERO_ADDR, 32'h0);
    for (int f = 1; f < 4; f++)
    begin
      host.wr(SETUP_ADDR, 32'(f));
      zx_lvl <= 1'b0;
      repeat (3) @(posedge clk);
      check("zx_low", {31'h0, ev_n}, 32'h0);
      zx_lvl <= 1'b1;
      repeat (3) @(posedge clk);
      check("zx_high", {31'h0, ev_n}, 32'h1);
    end
    n = 0;
    m = 0;
    repeat (2200)
    begin
      @(posedge clk);
      n += (ev_n !== 1'b1);
      m += (irq_n !== 1'b1);
    end
    check("no_pulse", n, 32'h0);
    check("irq_masked", m, 32'h0);
    tally_and_finish();
  end
endmodule
`default_nettype wire

// ==== verification/vcd_host.sv ====
// host model: register access over the device port and burst read on the event pin
`default_nettype none
module vcd_host (
  // clock
  input wire logic clk_i,
  // register port
  output var vcd_pkg::vcd_reg_req_t req_o,
  input wire vcd_pkg::vcd_reg_rsp_t rsp_i,
  // event pin of the device
  input wire logic event_pin_n_i
);
  timeunit 1ns;
  timeprecision 1ps;
  import vcd_pkg::*;
  logic [31:0] burst_q [NCH];
  initial req_o = '0;
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk_i);
    req_o <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_i);
    req_o <= '0;
  endtask
  // a missing answer yields unknowns so that every compare on it fails
  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    @(posedge clk_i);
    req_o <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk_i);
    req_o <= '0;
    #1;
    d = (rsp_i.rvalid === 1'b1) ? rsp_i.rdata : 'x;
  endtask
  // waits out one whole low pulse, then reads every sample word back to back
  task automatic burst(output int ok);
    int n;
    n = 0;
    while (event_pin_n_i !== 1'b0 && n < 3000)
    begin
      @(posedge clk_i);
      n++;
    end
    while (event_pin_n_i !== 1'b1 && n < 6000)
    begin
      @(posedge clk_i);
      n++;
    end
    ok = (n < 6000);
    for (int i = 0; i < NCH; i++)
      rd(WAVE_BASE + 16'(i), burst_q[i]);
  endtask
endmodule
`default_nettype wire
